// ---- gmma_pkg.sv ----
// Shared constants and types of the gauge memory map and accumulators
package gmma_pkg;

    // Internal time base and derived cycle counts
    localparam int unsigned CLK_HZ = 200_000_000;  // Core clock rate
    localparam int unsigned HALF_SEC_MS = 500;  // Accumulation interval, ms
    localparam int unsigned TIME_RATE_HZ = 2;  // Time count rate, Hz
    localparam int unsigned HALF_SEC_CYCLES = (CLK_HZ / 1000) * HALF_SEC_MS;
    localparam int unsigned TIME_TICK_CYCLES = CLK_HZ / TIME_RATE_HZ;
    localparam int unsigned EE_WRITE_MS = 4;  // Nonvolatile byte write time, ms
    localparam int unsigned EE_WRITE_CYCLES = (CLK_HZ / 1000) * EE_WRITE_MS;

    // Bus slave address (arbitrary neutral value)
    localparam logic [6:0] SLAVE_ADDR = 7'h2b;

    // Bank select codes
    localparam logic [1:0] BANK_EEPROM = 2'h0;  // Nonvolatile array
    localparam logic [1:0] BANK_REGS = 2'h1;  // SRAM and operational registers
    localparam logic [1:0] BANK_TEST = 2'h2;  // Test registers, none built
    localparam logic [1:0] BANK_RSVD = 2'h3;  // Reserved

    // Sizes and offsets inside banks
    localparam int unsigned EE_BYTES = 256;
    localparam int unsigned SRAM_BYTES = 32;
    localparam int unsigned ACC_COUNT = 6;
    localparam logic [9:0] EE_LAST = 10'h0ff;
    localparam logic [9:0] SRAM_LAST = 10'h01f;
    localparam logic [9:0] OFS_DISCHARGE_SUM = 10'h020;
    localparam logic [9:0] OFS_DISCHARGE_TIME = 10'h024;
    localparam logic [9:0] OFS_CHARGE_SUM = 10'h028;
    localparam logic [9:0] OFS_CHARGE_TIME = 10'h02c;
    localparam logic [9:0] OFS_TEMP_SUM = 10'h030;
    localparam logic [9:0] OFS_TEMP_TIME = 10'h034;
    localparam logic [9:0] OFS_ACC_LAST = 10'h037;
    localparam logic [9:0] OFS_ACC_CLEAR = 10'h062;  // accumulator_clear byte
    localparam logic [9:0] OFS_ACC_CTRL = 10'h063;  // accumulation_control byte

    // Accumulator channel numbers, also clear bit positions
    localparam int unsigned CH_DISCHARGE_SUM = 0;
    localparam int unsigned CH_DISCHARGE_TIME = 1;
    localparam int unsigned CH_CHARGE_SUM = 2;
    localparam int unsigned CH_CHARGE_TIME = 3;
    localparam int unsigned CH_TEMP_SUM = 4;
    localparam int unsigned CH_TEMP_TIME = 5;

    // Reset values
    localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;

    // Twelve-bit location: bank plus ten-bit offset
    typedef struct packed {
        logic [1:0] bank;
        logic [9:0] offset;
    } gmma_loc_t;

    // accumulation_control layout
    typedef struct packed {
        logic [4:0] unused;
        logic temp_sel;  // 0 internal sensor, 1 external thermistor
        logic temp_en;  // Temperature accumulation enable
        logic cur_en;  // Current accumulation enable
    } gmma_ctrl_t;

    // One accepted byte write
    typedef struct packed {
        logic valid;
        gmma_loc_t loc;
        logic [7:0] data;
    } gmma_wr_t;

    // Byte protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_SEND,
        ST_MACK
    } gmma_state_t;

endpackage

// ---- gmma_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gmma_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_async,
    output logic o_level
);
    logic s1_reg;  // Metastable stage, read only by s2
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    // Shift chain; level moves only once stages two and three agree
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
            level_reg <= RESET_VAL;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign o_level = level_reg;
endmodule

// ---- gmma_accum.sv ----
// One wrapping 32-bit accumulator with clear
`timescale 1ns/1ps
module gmma_accum (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_add,
    input wire logic [31:0] i_value,
    output logic [31:0] o_value
);
    import gmma_pkg::*;

    logic [31:0] value_reg;
    logic [31:0] value_next;

    // Clear then add, so a sample landing on a clear is kept
    always_comb begin
        value_next = (i_clear ? ACC_RESET : value_reg) + (i_add ? i_value : 32'h0000_0000);
    end

    // Plain 32-bit sum wraps past all ones, no saturation
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            value_reg <= ACC_RESET;
        end else begin
            value_reg <= value_next;  // RULE13 RULE18
        end
    end

    assign o_value = value_reg;
endmodule

// ---- gmma_top.sv ----
// Gauge memory map: serial slave, EEPROM, SRAM and accumulators
//
// Summary of operation
// RULE1 - Decode twelve-bit location: bank plus offset
// RULE2 - Banks: EEPROM, SRAM/registers, test, reserved
// RULE3 - Bus commands only read or write locations
// RULE4 - EEPROM holds 256 bytes in bank 0
// RULE5 - EEPROM reads any length, writes single bytes
// RULE6 - Each EEPROM byte write busy four ms
// RULE7 - Acknowledge EEPROM write at once when idle
// RULE8 - Refuse EEPROM access while write is busy
// RULE9 - SRAM and registers unaffected by EEPROM busy
// RULE10 - 32 bytes SRAM in bank 1, byte/block
// RULE11 - Discharge sum adds magnitude when sign set
// RULE12 - Charge sum adds magnitude when sign clear
// RULE13 - Sums wrap on overflow, never saturate
// RULE14 - Discharge time counts at 2 Hz
// RULE15 - Charge time counts at 2 Hz
// RULE16 - Temperature sum adds selected sensor result
// RULE17 - Temperature time counts at 2 Hz
// RULE18 - Six clear bits zero six accumulators
// RULE19 - Pull data low through acknowledge clock
// RULE20 - One divider ticks all; magnitude is absolute
// RULE21 - Busy flag set on write, cleared by timer
`timescale 1ns/1ps
module gmma_top #(
    parameter int unsigned P_HALF_SEC_CYCLES = gmma_pkg::HALF_SEC_CYCLES,
    parameter int unsigned P_EE_WRITE_CYCLES = gmma_pkg::EE_WRITE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic [15:0] i_current_result,
    input wire logic [15:0] i_internal_temp,
    input wire logic [15:0] i_external_temp,
    output logic o_eeprom_busy
);
    import gmma_pkg::*;

    // Filtered pin levels and their previous values
    logic scl_f;
    logic sda_f;
    logic scl_q_reg;
    logic sda_q_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Protocol state
    gmma_state_t state_reg;
    logic [3:0] bit_cnt_reg;  // Bits seen or sent in current byte
    logic [1:0] byte_idx_reg;  // 0 slave address, 1 high, 2 low, 3 data
    logic [7:0] shift_reg;  // Received byte
    logic [7:0] tx_reg;  // Byte being sent
    logic [7:0] addr_hi_reg;  // First address byte, bank and offset top
    logic reading_reg;  // Slave address carried the read bit
    logic m_ack_reg;  // Master acknowledged the last sent byte
    logic sda_oe_reg;  // Drive data low
    gmma_loc_t ptr_reg;  // Current location, auto-increments
    gmma_wr_t wr_reg;  // One-cycle accepted write

    // Storage and control
    logic [7:0] eeprom_mem [EE_BYTES];
    logic [7:0] sram_mem [SRAM_BYTES];
    gmma_ctrl_t ctrl_reg;
    logic [5:0] clr_reg;  // One-cycle clear strobes
    logic ee_busy_reg;
    logic [31:0] ee_cnt_reg;
    logic [31:0] tick_cnt_reg;
    logic tick_reg;

    // Decode helpers
    logic ack_ok;
    logic ee_target;
    logic ee_hit_busy;
    logic [7:0] rd_data;
    logic [9:0] acc_rel;
    logic [15:0] cur_mag;
    logic cur_sign;
    logic [15:0] temp_pick;

    // Accumulator bank wiring
    logic [ACC_COUNT-1:0] acc_add;
    logic [31:0] acc_val [ACC_COUNT];
    logic [31:0] acc_q [ACC_COUNT];

    // Pin synchronisers, idle high
    gmma_sync #(.RESET_VAL(1'b1)) u_sync_scl (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_async(i_scl),
        .o_level(scl_f)
    );

    gmma_sync #(.RESET_VAL(1'b1)) u_sync_sda (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_async(i_sda),
        .o_level(sda_f)
    );

    // Previous filtered levels for edge detection
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_f;
            sda_q_reg <= sda_f;
        end
    end

    // Bus conditions; data changes only with clock high mark start/stop
    assign scl_rise = scl_f & ~scl_q_reg;
    assign scl_fall = ~scl_f & scl_q_reg;
    assign start_det = scl_f & scl_q_reg & sda_q_reg & ~sda_f;
    assign stop_det = scl_f & scl_q_reg & ~sda_q_reg & sda_f;

    // Acknowledge decision for the byte just received
    always_comb begin
        ee_target = (ptr_reg.bank == BANK_EEPROM);
        ee_hit_busy = ee_target & ee_busy_reg;
        ack_ok = 1'b0;
        unique case (byte_idx_reg)
            2'd0: begin
                // Read of busy EEPROM refused at the slave address
                ack_ok = (shift_reg[7:1] == SLAVE_ADDR) & ~(shift_reg[0] & ee_hit_busy);  // RULE8
            end
            2'd1: begin
                ack_ok = 1'b1;
            end
            2'd2: begin
                // Pointing at a busy EEPROM is refused too
                ack_ok = ~((addr_hi_reg[3:2] == BANK_EEPROM) & ee_busy_reg);  // RULE8 RULE21
            end
            2'd3: begin
                // Only bank 0 waits on the busy flag
                ack_ok = ~ee_hit_busy;  // RULE7 RULE8 RULE9
            end
        endcase
    end

    // Byte-level serial slave; a start always restarts the frame
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 2'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            addr_hi_reg <= 8'h00;
            reading_reg <= 1'b0;
            m_ack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            ptr_reg <= '0;
            wr_reg <= '0;
        end else begin
            wr_reg.valid <= 1'b0;
            if (start_det) begin
                state_reg <= ST_RECV;
                bit_cnt_reg <= 4'h0;
                byte_idx_reg <= 2'h0;
                sda_oe_reg <= 1'b0;
            end else if (stop_det) begin
                state_reg <= ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else begin
                unique case (state_reg)
                    ST_IDLE: begin
                        sda_oe_reg <= 1'b0;  // Wait for a start
                    end
                    ST_RECV: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_f};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            // Drive acknowledge from the low phase onward
                            state_reg <= ST_ACK;
                            sda_oe_reg <= ack_ok;  // RULE19
                            if (byte_idx_reg != 2'd3) begin
                                byte_idx_reg <= byte_idx_reg + 2'd1;
                            end
                            unique case (byte_idx_reg)
                                2'd0: begin
                                    reading_reg <= shift_reg[0];
                                end
                                2'd1: begin
                                    addr_hi_reg <= shift_reg;
                                end
                                2'd2: begin
                                    ptr_reg <= {addr_hi_reg[3:0], shift_reg};  // RULE1
                                end
                                2'd3: begin
                                    // Data byte: store and step the pointer
                                    if (ack_ok) begin
                                        wr_reg.valid <= 1'b1;  // RULE3
                                        wr_reg.loc <= ptr_reg;
                                        wr_reg.data <= shift_reg;
                                        ptr_reg.offset <= ptr_reg.offset + 10'h001;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        // Hold through the whole high phase, release on fall
                        if (scl_fall) begin
                            if (!sda_oe_reg) begin
                                state_reg <= ST_IDLE;
                            end else if (reading_reg) begin
                                state_reg <= ST_SEND;
                                tx_reg <= rd_data;
                                sda_oe_reg <= ~rd_data[7];
                                bit_cnt_reg <= 4'h1;
                                ptr_reg.offset <= ptr_reg.offset + 10'h001;
                            end else begin
                                state_reg <= ST_RECV;
                                sda_oe_reg <= 1'b0;
                                bit_cnt_reg <= 4'h0;
                            end
                        end
                    end
                    ST_SEND: begin
                        // Next bit placed while clock is low
                        if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                state_reg <= ST_MACK;
                                sda_oe_reg <= 1'b0;
                            end else begin
                                sda_oe_reg <= ~tx_reg[3'd7 - bit_cnt_reg[2:0]];
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            m_ack_reg <= ~sda_f;
                        end else if (scl_fall) begin
                            // Block read continues while the master acknowledges
                            if (m_ack_reg) begin
                                state_reg <= ST_SEND;
                                tx_reg <= rd_data;
                                sda_oe_reg <= ~rd_data[7];
                                bit_cnt_reg <= 4'h1;
                                ptr_reg.offset <= ptr_reg.offset + 10'h001;  // RULE5
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Read data for the current location; unmapped bytes read zero
    always_comb begin
        rd_data = 8'h00;
        acc_rel = ptr_reg.offset - OFS_DISCHARGE_SUM;
        unique case (ptr_reg.bank)  // RULE2
            BANK_EEPROM: begin
                if (ptr_reg.offset <= EE_LAST) begin
                    rd_data = eeprom_mem[ptr_reg.offset[7:0]];  // RULE4
                end
            end
            BANK_REGS: begin
                if (ptr_reg.offset <= SRAM_LAST) begin
                    rd_data = sram_mem[ptr_reg.offset[4:0]];  // RULE10
                end else if (ptr_reg.offset >= OFS_DISCHARGE_SUM
                             && ptr_reg.offset <= OFS_ACC_LAST) begin
                    // Little-endian bytes; no snapshot, so host reads may tear
                    rd_data = acc_q[acc_rel[4:2]][{acc_rel[1:0], 3'b000} +: 8];
                end else if (ptr_reg.offset == OFS_ACC_CTRL) begin
                    rd_data = ctrl_reg;
                end
            end
            BANK_TEST: begin
                rd_data = 8'h00;  // No test registers implemented
            end
            BANK_RSVD: begin
                rd_data = 8'h00;
            end
        endcase
    end

    // Nonvolatile array; contents survive reset
    always_ff @(posedge i_clock) begin
        if (wr_reg.valid && wr_reg.loc.bank == BANK_EEPROM && wr_reg.loc.offset <= EE_LAST) begin
            eeprom_mem[wr_reg.loc.offset[7:0]] <= wr_reg.data;  // RULE4 RULE5
        end
    end

    // Scratch SRAM
    always_ff @(posedge i_clock) begin
        if (wr_reg.valid && wr_reg.loc.bank == BANK_REGS && wr_reg.loc.offset <= SRAM_LAST) begin
            sram_mem[wr_reg.loc.offset[4:0]] <= wr_reg.data;  // RULE10
        end
    end

    // Busy timer: one write per cycle, other EEPROM accesses refused meanwhile
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ee_busy_reg <= 1'b0;
            ee_cnt_reg <= 32'h0000_0000;
        end else if (wr_reg.valid && wr_reg.loc.bank == BANK_EEPROM
                     && wr_reg.loc.offset <= EE_LAST) begin
            ee_busy_reg <= 1'b1;  // RULE21
            ee_cnt_reg <= 32'(P_EE_WRITE_CYCLES - 1);  // RULE6
        end else if (ee_busy_reg) begin
            if (ee_cnt_reg == 32'h0000_0000) begin
                ee_busy_reg <= 1'b0;  // RULE21
            end else begin
                ee_cnt_reg <= ee_cnt_reg - 32'h0000_0001;
            end
        end
    end

    // Control byte and self-clearing clear strobes
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= ACC_CTRL_RESET;
            clr_reg <= 6'h00;
        end else begin
            clr_reg <= 6'h00;
            if (wr_reg.valid && wr_reg.loc.bank == BANK_REGS) begin
                if (wr_reg.loc.offset == OFS_ACC_CTRL) begin
                    ctrl_reg <= wr_reg.data;  // RULE3
                end
                if (wr_reg.loc.offset == OFS_ACC_CLEAR) begin
                    clr_reg <= wr_reg.data[5:0];  // RULE18
                end
            end
        end
    end

    // Shared half-second divider drives every sum and time count
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == 32'(P_HALF_SEC_CYCLES - 1)) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;  // RULE20
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end

    // Sample sign, magnitude and temperature source
    always_comb begin
        cur_sign = i_current_result[15];
        cur_mag = cur_sign ? (~i_current_result + 16'h0001) : i_current_result;  // RULE20
        temp_pick = ctrl_reg.temp_sel ? i_external_temp : i_internal_temp;  // RULE16
    end

    // Per-channel add enables and addends
    always_comb begin
        acc_add[CH_DISCHARGE_SUM] = tick_reg & ctrl_reg.cur_en & cur_sign;  // RULE11
        acc_add[CH_DISCHARGE_TIME] = tick_reg & ctrl_reg.cur_en & cur_sign;  // RULE14
        acc_add[CH_CHARGE_SUM] = tick_reg & ctrl_reg.cur_en & ~cur_sign;  // RULE12
        acc_add[CH_CHARGE_TIME] = tick_reg & ctrl_reg.cur_en & ~cur_sign;  // RULE15
        acc_add[CH_TEMP_SUM] = tick_reg & ctrl_reg.temp_en;  // RULE16
        acc_add[CH_TEMP_TIME] = tick_reg & ctrl_reg.temp_en;  // RULE17
        acc_val[CH_DISCHARGE_SUM] = {16'h0000, cur_mag};
        acc_val[CH_DISCHARGE_TIME] = 32'h0000_0001;
        acc_val[CH_CHARGE_SUM] = {16'h0000, cur_mag};
        acc_val[CH_CHARGE_TIME] = 32'h0000_0001;
        acc_val[CH_TEMP_SUM] = {16'h0000, temp_pick};
        acc_val[CH_TEMP_TIME] = 32'h0000_0001;
    end

    // Six identical wrapping accumulators
    for (genvar g = 0; g < ACC_COUNT; g++) begin : g_acc
        gmma_accum u_acc (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_clear(clr_reg[g]),
            .i_add(acc_add[g]),
            .i_value(acc_val[g]),
            .o_value(acc_q[g])
        );
    end

    // Open-drain data: only ever pulls low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe_reg;
    assign o_eeprom_busy = ee_busy_reg;
endmodule

// ---- gmma_checker.sv ----
// Port assertions for the gauge memory map block
`timescale 1ns/1ps
module gmma_checker #(
    parameter int unsigned P_HALF_SEC_CYCLES = 100,
    parameter int unsigned P_EE_WRITE_CYCLES = 100
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic [15:0] i_current_result,
    input wire logic [15:0] i_internal_temp,
    input wire logic [15:0] i_external_temp,
    input wire logic o_eeprom_busy
);
    logic [31:0] busy_cycles_reg; // Age of the running write cycle
    // Busy clocks
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) busy_cycles_reg <= 32'h0;
        else busy_cycles_reg <= o_eeprom_busy ? busy_cycles_reg + 32'h1 : 32'h0;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // Steps around a write cycle
    sequence busy_hold; o_eeprom_busy [*8]; endsequence
    sequence busy_idle; !o_eeprom_busy [*8]; endsequence
    sda_low_a: assert property (o_sda_out == 1'b0) else $error("sda value high");
    drive_stable_a: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("drive moved with clock high");
    ack_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*4])
        else $error("drive too short");
    busy_ack_a: assert property ($rose(o_eeprom_busy) |-> o_sda_oe)
        else $error("busy without ack");
    busy_min_a: assert property ($rose(o_eeprom_busy) |-> busy_hold)
        else $error("busy too short");
    busy_len_a: assert property ($fell(o_eeprom_busy) |->
        busy_cycles_reg >= P_EE_WRITE_CYCLES - 2 && busy_cycles_reg <= P_EE_WRITE_CYCLES + 2)
        else $error("busy length wrong");
    busy_cap_a: assert property (busy_cycles_reg <= P_EE_WRITE_CYCLES + 2)
        else $error("busy never ends");
    busy_gap_a: assert property ($fell(o_eeprom_busy) |-> busy_idle)
        else $error("busy restarted alone");
endmodule
bind gmma_top gmma_checker #(.P_HALF_SEC_CYCLES(P_HALF_SEC_CYCLES),
    .P_EE_WRITE_CYCLES(P_EE_WRITE_CYCLES)) chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .i_current_result(i_current_result), .i_internal_temp(i_internal_temp),
    .i_external_temp(i_external_temp), .o_eeprom_busy(o_eeprom_busy));

// ---- gmma_host.sv ----
// Two-wire bus master model
`timescale 1ns/1ps
module gmma_host (
    input wire logic i_clock,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // Bus idle: both lines released
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // Third of a bit; clock lows span two, above the ten-clock minimum
    task automatic gap();
        repeat (12) @(posedge i_clock);
    endtask
    // Start or repeated start, clock left low
    task automatic start();
        gap();
        o_sda <= 1'b1;
        gap();
        o_scl <= 1'b1;
        gap();
        o_sda <= 1'b0;
        gap();
        o_scl <= 1'b0;
    endtask
    // Stop; data pulled low with the clock low, released with the clock high
    task automatic stop();
        gap();
        o_sda <= 1'b0;
        gap();
        o_scl <= 1'b1;
        gap();
        o_sda <= 1'b1;
    endtask
    // Eight bits msb first plus the acknowledge slot, wire sampled high
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            gap();
            o_sda <= d[i];
            gap();
            o_scl <= 1'b1;
            gap();
            q[i] = i_sda;
            o_scl <= 1'b0;
        end
    endtask
endmodule

// ---- gauge_memory_map_accumulators_bench.sv ----
// Self-checking bench for the gauge memory map
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end
module gauge_memory_map_accumulators_bench;
    import gmma_pkg::*;
    localparam int unsigned HALF = 3000; // Shortened half second
    localparam int unsigned EEW = 6000; // Shortened write cycle
    logic i_clock;
    logic i_rst_n;
    logic [15:0] cur, t_in, t_ex;
    wire logic h_scl, h_sda, oe, busy, sda;
    int miscompares = 0;
    int checks_done = 0;
    logic [8:0] q;
    logic [7:0] rd [24]; // Bytes of the last read
    assign sda = h_sda & ~oe; // Open drain with pull-up
    gmma_top #(.P_HALF_SEC_CYCLES(HALF), .P_EE_WRITE_CYCLES(EEW)) uut (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_scl(h_scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(oe),
        .i_current_result(cur), .i_internal_temp(t_in), .i_external_temp(t_ex),
        .o_eeprom_busy(busy));
    gmma_host host (.i_clock(i_clock), .i_sda(sda), .o_scl(h_scl), .o_sda(h_sda));
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    // Verdict and end of run
    task automatic results();
        if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Start, device address, bank and offset bytes
    task automatic point(input logic [11:0] loc);
        logic [8:0] a, b, c;
        host.start();
        host.xfer({SLAVE_ADDR, 2'b01}, a);
        host.xfer({4'h0, loc[11:8], 1'b1}, b);
        host.xfer({loc[7:0], 1'b1}, c);
        `CHK({a[0], b[0], c[0]}, 3'b000)
    endtask
    // Write n bytes, low byte first; refusal bits returned
    task automatic put(input logic [11:0] loc, input logic [15:0] d, input int n,
        output logic [1:0] nak);
        point(loc);
        for (int i = 0; i < n; i++) begin
            host.xfer({d[8*i +: 8], 1'b1}, q);
            nak[i] = q[0];
        end
        host.stop();
    endtask
    // Read n bytes; the master refuses the last one
    task automatic get(input logic [11:0] loc, input int n);
        point(loc);
        host.start();
        host.xfer({SLAVE_ADDR, 2'b11}, q);
        `CHK(q[0], 1'b0)
        for (int i = 0; i < n; i++) begin
            host.xfer({8'hff, i == n - 1}, q);
            rd[i] = q[8:1];
        end
        host.stop();
    endtask
    // Top two scratch bytes as one block
    task automatic sram_test();
        logic [1:0] nak;
        put(12'h41e, 16'hc35a, 2, nak);
        `CHK(nak, 2'b00)
        get(12'h41e, 2);
        `CHK({rd[1], rd[0]}, 16'hc35a)
    endtask
    // Block write to the last array byte; scratch use while busy
    task automatic ee_test();
        logic [1:0] nak;
        int n;
        put(12'h0ff, 16'h6ba5, 2, nak);
        `CHK(nak, 2'b10)
        put(12'h400, 16'h0077, 1, nak);
        `CHK({busy, nak[0]}, 2'b10)
        get(12'h400, 1);
        `CHK(rd[0], 8'h77)
        // Retry only after the cycle ends
        for (n = 0; busy && n < 2 * EEW; n++) @(posedge i_clock);
        `CHK(busy, 1'b0)
        get(12'h0ff, 1);
        `CHK(rd[0], 8'ha5)
    endtask
    // Clear all, enable, run about three ticks, stop, read all six counters
    task automatic acc_test(input logic [15:0] c, input logic [7:0] ctl);
        logic [1:0] nak;
        logic [31:0] v [6];
        logic [31:0] m, t, k;
        cur <= c;
        put(12'h462, {ctl, 8'h3f}, 2, nak);
        repeat (3 * HALF) @(posedge i_clock);
        put(12'h463, 16'h0000, 1, nak);
        get(12'h420, 24);
        for (int i = 0; i < 6; i++) v[i] = {rd[4*i+3], rd[4*i+2], rd[4*i+1], rd[4*i]};
        m = {16'h0, c[15] ? 16'(-c) : c};
        t = {16'h0, ctl[2] ? t_ex : t_in};
        k = c[15] ? v[1] : v[3];
        `CHK(k >= 3 && k <= 4, 1'b1)
        `CHK(v[c[15] ? 0 : 2], k * m)
        `CHK({v[c[15] ? 2 : 0], v[c[15] ? 3 : 1]}, 64'h0)
        `CHK(v[5], k)
        `CHK(v[4], k * t)
    endtask
    initial begin
        i_rst_n = 1'b0;
        cur = 16'h0;
        t_in = 16'h0123;
        t_ex = 16'h0456;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (10) @(posedge i_clock);
        sram_test();
        ee_test();
        acc_test(16'h0005, 8'h03);
        acc_test(16'h8000, 8'h07);
        results();
    end
    // Hang guard, about twice the expected run
    initial begin
        repeat (100000) @(posedge i_clock);
        miscompares++;
        results();
    end
endmodule
